//--- timer3_map.vh
`ifndef TIMER3_MAP_VH
`define TIMER3_MAP_VH
// register byte addresses
`define ADDR_MODE        12'h000
`define ADDR_THIRD_CTRL  12'h004
`define ADDR_COUNT       12'h008
`define ADDR_PERIOD      12'h00c
// mode register fields
`define BIT_POLARITY     7
`define BIT_WIDE         6
`define BIT_PWM_EN       5
`define BIT_CAPTURE      4
`define BIT_CKSEL_HI     3
`define BIT_CKSEL_LO     2
`define BIT_RUN          1
`define BIT_RESTART      0
`define MODE_RESET       8'h00
// clock select codes
`define CKSEL_OSC        2'h0
`define CKSEL_DIV4       2'h1
`define CKSEL_DIV16      2'h2
`define CKSEL_THIRD      2'h3
// third timer control fields
`define BIT_THIRD_RUN    1
`define BIT_THIRD_RESTART 0
`define PERIOD_RESET     8'hff
`endif

//--- prescale_tick.v
`timescale 1ns/100ps
`default_nettype none
// free running divider giving one-cycle ticks at /4 and /16
module prescale_tick #(
   parameter WIDTH = 4
) (
   input  wire             clk,
   input  wire             reset,
   output wire             tick_div4,
   output wire             tick_div16
);
   reg [WIDTH-1:0] cnt_q;
   always @(posedge clk) begin
      if (reset)
         cnt_q <= {WIDTH{1'b0}};
      else
         cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
   end
   assign tick_div4  = (cnt_q[1:0] == 2'h3);
   assign tick_div16 = (cnt_q[3:0] == 4'hf);
endmodule // prescale_tick
`default_nettype wire

//--- timer3_mode_control.v
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "timer3_map.vh"
module timer3_mode_control (
   input  wire        clk,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        capture_pin,
   output reg         pwm_out,
   output reg  [7:0]  capture_value,
   output reg         capture_event
);
   reg  [7:0] mode_q;
   reg  [1:0] third_ctrl_q;
   reg  [7:0] third_count_q;
   reg  [7:0] count_q;
   reg  [7:0] period_q;
   reg        cap_meta_q;
   reg        cap_sync_q;
   reg        cap_prev_q;
   wire       tick_div4;
   wire       tick_div16;
   wire       wr_en;
   wire       rd_en;
   wire       mode_wr;
   wire       third_wr;
   wire       period_wr;
   wire       mode_restart;
   wire       third_restart;
   wire       duty_active;
   wire       cap_take;
   reg  [31:0] rd_word;
   wire       addr_ok;
   reg        src_tick;
   wire       third_run;
   wire       run;
   wire       wide;
   wire       third_wrap;
   wire       cap_rise;

   prescale_tick #(.WIDTH(4)) u_prescale (
      .clk        (clk),
      .reset      (reset),
      .tick_div4  (tick_div4),
      .tick_div16 (tick_div16)
   );

   // zero wait states; unmapped addresses answer with pslverr
   assign pready  = 1'b1;
   assign addr_ok = (paddr == `ADDR_MODE) || (paddr == `ADDR_THIRD_CTRL) ||
                    (paddr == `ADDR_COUNT) || (paddr == `ADDR_PERIOD);
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en   = psel & penable & pwrite & addr_ok;
   assign rd_en   = psel & ~penable & ~pwrite;

   // per-register write strobes; a restart write outranks counting so the count is zero right after that write
   assign mode_wr       = wr_en & (paddr == `ADDR_MODE);
   assign third_wr      = wr_en & (paddr == `ADDR_THIRD_CTRL);
   assign period_wr     = wr_en & (paddr == `ADDR_PERIOD);
   assign mode_restart  = mode_wr & pwdata[`BIT_RESTART];
   assign third_restart = third_wr & pwdata[`BIT_THIRD_RESTART];

   assign third_run  = third_ctrl_q[`BIT_THIRD_RUN] & third_ctrl_q[`BIT_THIRD_RESTART];
   assign run        = mode_q[`BIT_RUN] & mode_q[`BIT_RESTART];
   assign wide       = mode_q[`BIT_WIDE];
   assign third_wrap = third_run & (third_count_q == 8'hff);

   // count source select; the wide cascade ignores it and steps only on third_wrap
   always @* begin
      case ({mode_q[`BIT_CKSEL_HI], mode_q[`BIT_CKSEL_LO]})
         `CKSEL_OSC:   src_tick = 1'b1;
         `CKSEL_DIV4:  src_tick = tick_div4;
         `CKSEL_DIV16: src_tick = tick_div16;
         `CKSEL_THIRD: src_tick = third_run;
         default:      src_tick = 1'b0;
      endcase
   end

   // mode register, fully read/write
   always @(posedge clk) begin
      if (reset) begin
         mode_q       <= `MODE_RESET;
         third_ctrl_q <= 2'h0;
         period_q     <= `PERIOD_RESET;
      end else begin
         if (mode_wr)
            mode_q <= pwdata[7:0];
         if (third_wr)
            third_ctrl_q <= pwdata[1:0];
         if (period_wr)
            period_q <= pwdata[7:0];
      end
   end

   // third timer count; writing restart 1 clears it
   always @(posedge clk) begin
      if (reset)
         third_count_q <= 8'h00;
      else if (third_restart)
         third_count_q <= 8'h00;
      else if (third_run)
         third_count_q <= third_count_q + 8'h01;
   end

   // fourth timer count: plain 8-bit, or upper byte when cascaded
   always @(posedge clk) begin
      if (reset)
         count_q <= 8'h00;
      else if (mode_restart)
         count_q <= 8'h00;
      else if (run) begin
         if (wide) begin
            if (third_wrap)
               count_q <= count_q + 8'h01;
         end else if (src_tick) begin
            if (count_q == period_q && !mode_q[`BIT_PWM_EN])
               count_q <= 8'h00; // period match restarts the timer
            else
               count_q <= count_q + 8'h01;
         end
      end
   end

   // pwm: duty while count below period compare
   // period 00 never reaches duty, so the pin rests at its idle level
   assign duty_active = (count_q < period_q);

   always @(posedge clk) begin
      if (reset)
         pwm_out <= 1'b0;
      else if (mode_q[`BIT_PWM_EN])
         pwm_out <= duty_active ~^ mode_q[`BIT_POLARITY];
      else
         pwm_out <= 1'b0;
   end

   // capture input: two stage sync before any edge detect
   always @(posedge clk) begin
      if (reset) begin
         cap_meta_q <= 1'b0;
         cap_sync_q <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         cap_meta_q <= capture_pin;
         cap_sync_q <= cap_meta_q;
         cap_prev_q <= cap_sync_q;
      end
   end
   assign cap_rise = cap_sync_q & ~cap_prev_q;
   // pin edges reach the count about three cycles late; the price of synchronising
   assign cap_take = cap_rise & mode_q[`BIT_CAPTURE];

   always @(posedge clk) begin
      if (reset) begin
         capture_value <= 8'h00;
         capture_event <= 1'b0;
      end else begin
         capture_event <= cap_take;
         if (cap_take)
            capture_value <= count_q;
      end
   end

   // read mux; both count bytes come from one edge, so a cascaded read never tears
   always @* begin
      case (paddr)
         `ADDR_MODE:       rd_word = {24'h000000, mode_q};
         `ADDR_THIRD_CTRL: rd_word = {30'h00000000, third_ctrl_q};
         `ADDR_COUNT:      rd_word = {16'h0000, count_q, third_count_q};
         `ADDR_PERIOD:     rd_word = {24'h000000, period_q};
         default:          rd_word = 32'h00000000;
      endcase
   end

   // read data registered in the setup cycle, ready in access phase
   always @(posedge clk) begin
      if (reset)
         prdata <= 32'h00000000;
      else if (rd_en)
         prdata <= rd_word;
   end
endmodule // timer3_mode_control
`default_nettype wire

//--- timer3_checker.sv
`timescale 1ns/100ps
`default_nettype none
module timer3_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pwm_out,
   input wire logic        capture_event
);
   logic [7:0] mode_q;
   wire        acc = psel && penable;
   // shadow of the mode register, written at the completing edge only
   always @(posedge clk) mode_q <= reset ? 8'h00 : acc && pwrite && paddr == 12'h000 ? pwdata[7:0] : mode_q;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ready_high_a: assert property (pready) else $error("pready low");
   err_unmapped_a: assert property (acc && paddr > 12'h00c |-> pslverr) else $error("no slverr");
   err_mapped_a: assert property (acc && paddr == 12'h000 |-> !pslverr) else $error("bad slverr");
   mode_read_a: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata == {24'h000000, mode_q})
      else $error("mode readback");
   reset_zero_a: assert property (disable iff (1'b0) reset |=> prdata == 32'h0 && !pwm_out)
      else $error("reset values");
   pwm_off_a: assert property ((!mode_q[5]) [*3] |-> !pwm_out) else $error("pwm while off");
   cap_off_a: assert property ((!mode_q[4]) [*6] |-> !capture_event) else $error("capture off");
   cap_pulse_a: assert property (capture_event |=> !capture_event) else $error("long pulse");
   cover property (acc && pwrite);
   cover property (capture_event);
   cover property (acc && pslverr);
endmodule // timer3_checker
bind timer3_mode_control timer3_checker u_timer3_checker (.clk, .reset, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pwm_out, .capture_event);
`default_nettype wire

//--- tb_timer3_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer3_map.vh"
module tb_timer3_mode_control;
   logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, capture_pin = 0, seen = 0;
   logic        pready, pslverr, er, pwm_out, capture_event;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, c, seed = 32'h4c41fcf1;
   logic [7:0]  capture_value;
   logic [7:0]  mode_m = 8'h00;
   int          error_cnt = 0, n_compared = 0, i;
   always #5 clk = ~clk;
   timer3_mode_control u_timer3_mode_control (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .capture_pin, .pwm_out, .capture_value, .capture_event);
   function logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1);
      rd = prdata;
      er = pslverr;
      if (w && a == `ADDR_MODE) mode_m = d[7:0];
      {psel, penable} <= 2'b00;
   endtask
   task give_verdict;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      give_verdict;
   end
   initial begin
      repeat (16) @(posedge clk);
      reset <= 0;
      apb(0, `ADDR_MODE, 0);
      chk("mode_reset", 0, rd);
      chk("mapped_ok", 0, er);
      for (i = 0; i < 4; i++) begin
         seed = xs(seed);
         apb(1, `ADDR_MODE, seed);
         apb(0, `ADDR_MODE, 0);
         chk("mode_rw", mode_m, rd);
      end
      apb(0, 12'h010, 0);
      chk("unmapped", 1, er);
      // each pass restarts from zero, then pauses or drops the restart bit
      for (i = 0; i < 3; i++) begin
         apb(1, `ADDR_MODE, 4 * i + 3);
         repeat (64) @(posedge clk);
         apb(1, `ADDR_MODE, 4 * i + 2 * (i % 2));
         apb(0, `ADDR_COUNT, 0);
         c = rd;
         chk("rate", 1, c[15:8] >= 64 >> 2 * i && c[15:8] <= (72 >> 2 * i) + 1);
         apb(0, `ADDR_COUNT, 0);
         chk("held", c, rd);
      end
      apb(1, `ADDR_MODE, 8'h13);
      capture_pin <= 1;
      repeat (12) begin
         @(posedge clk);
         seen |= capture_event;
      end
      chk("capture", 1, seen);
      chk("cap_value", 1, capture_value >= 1 && capture_value <= 4);
      apb(1, `ADDR_MODE, 8'ha0);
      repeat (2) @(posedge clk);
      chk("pwm_high", 1, pwm_out);
      apb(1, `ADDR_MODE, 8'h20);
      repeat (2) @(posedge clk);
      chk("pwm_low", 0, pwm_out);
      apb(1, `ADDR_PERIOD, 0);
      repeat (2) @(posedge clk);
      chk("pwm_idle", 1, pwm_out);
      apb(1, `ADDR_MODE, 0);
      repeat (2) @(posedge clk);
      chk("pwm_off", 0, pwm_out);
      // cascade: 304 third-timer steps give one carry into the upper byte
      apb(1, `ADDR_THIRD_CTRL, 3);
      apb(1, `ADDR_MODE, 8'h4f);
      repeat (300) @(posedge clk);
      apb(0, `ADDR_COUNT, 0);
      chk("cascade", 32'h00000130, rd);
      give_verdict;
   end
endmodule // tb_timer3_mode_control
`default_nettype wire
